// >>> test/swwd_core.sv
// swwd_core: core model issuing one-cycle sleep and clear pulses
// assumes: caller starts a pulse only while the core is clocked
`timescale 1ns/1ns
module swwd_core (
  input wire logic sys_clk,
  output logic sleep_instr,
  output logic watchdog_clear_instruction
);
  initial {sleep_instr, watchdog_clear_instruction} = 2'h0;
  task automatic pulse(input logic slp);
    @(posedge sys_clk);
    sleep_instr <= slp;
    watchdog_clear_instruction <= !slp;
    @(posedge sys_clk);
    {sleep_instr, watchdog_clear_instruction} <= 2'h0;
  endtask
endmodule

// >>> test/swwd_ctrl_sva.sv
// swwd_chk: port-level property checks for swwd_ctrl
// assumes: one sys_clk domain, rstn async active low
`timescale 1ns/1ns
module swwd_chk
  import swwd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] watchdog_mode_config,
  input wire logic sleep_instr,
  input wire logic irq_pending,
  input wire logic global_interrupt_enable,
  input wire logic lp_incompatible_active,
  input wire logic regulator_ready,
  input wire logic cpu_clk_en,
  input wire logic regulator_low_power,
  input wire logic call_isr,
  input wire logic [15:0] isr_vector,
  input wire logic wdt_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // set when low power ends at a wake edge, not because a peripheral forced normal mode
  logic lp_wait_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lp_wait_ff <= 1'b0;
    end else if (cpu_clk_en) begin
      lp_wait_ff <= 1'b0;
    end else if ($fell(regulator_low_power) && !$past(lp_incompatible_active)) begin
      lp_wait_ff <= 1'b1;
    end
  end
  sequence run_sleep;
    cpu_clk_en && sleep_instr;
  endsequence
  chk_nop_sleep: assert property (run_sleep ##0 irq_pending |=> cpu_clk_en)
    else $error("sleep not ignored");
  chk_sleep_entry: assert property (run_sleep ##0 !irq_pending |=> !cpu_clk_en)
    else $error("sleep not entered");
  chk_isr_on_wake: assert property (call_isr |-> $rose(cpu_clk_en) && global_interrupt_enable && isr_vector == ISR_VECTOR)
    else $error("bad service call");
  chk_mode_off: assert property ((watchdog_mode_config == MODE_OFF) [*2] |-> !wdt_reset)
    else $error("reset with watchdog off");
  chk_no_sleep_reset: assert property (!cpu_clk_en |-> !wdt_reset)
    else $error("reset while asleep");
  chk_lp_asleep: assert property (regulator_low_power |-> !cpu_clk_en)
    else $error("low power while running");
  chk_lp_blocked: assert property (lp_incompatible_active && $past(lp_incompatible_active) |-> !regulator_low_power)
    else $error("low power with busy peripheral");
  chk_lp_ready: assert property ($rose(cpu_clk_en) && lp_wait_ff |-> $past(regulator_ready))
    else $error("woke before regulator ready");
endmodule
bind swwd_ctrl swwd_chk u_swwd_chk (.sys_clk, .rstn, .watchdog_mode_config, .sleep_instr, .irq_pending,
  .global_interrupt_enable, .lp_incompatible_active, .regulator_ready, .cpu_clk_en, .regulator_low_power,
  .call_isr, .isr_vector, .wdt_reset);

// >>> test/swwd_ctrl_tb.sv
// swwd_ctrl_tb: register, sleep, regulator and watchdog tests
// assumes: swwd_core drives the instruction pulses, tick every 4 cycles
`timescale 1ns/1ns
module swwd_ctrl_tb;
  import swwd_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, global_interrupt_enable = 1'b0;
  logic irq_pending = 1'b0, osc_tick = 1'b0, osc_fail = 1'b0, oscillator_startup_timer = 1'b0;
  logic lp_incompatible_active = 1'b0, regulator_ready = 1'b0, sleep_instr, watchdog_clear_instruction;
  logic cpu_clk_en, regulator_low_power, call_isr, wdt_reset, irq;
  logic [1:0] watchdog_mode_config = MODE_SW, tcnt = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, n_rst = 8'h00, n_isr = 8'h00;
  logic [15:0] isr_vector;
  int bad_count = 0, n_checks = 0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tcnt <= tcnt + 2'h1;
    osc_tick <= (tcnt == 2'h3);
    n_rst <= n_rst + {7'h0, wdt_reset === 1'b1};
    n_isr <= n_isr + {7'h0, call_isr === 1'b1};
  end
  swwd_ctrl u_swwd_ctrl (.sys_clk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata, .watchdog_mode_config,
    .sleep_instr, .watchdog_clear_instruction, .global_interrupt_enable, .irq_pending, .osc_tick, .osc_fail,
    .oscillator_startup_timer, .lp_incompatible_active, .regulator_ready, .cpu_clk_en, .regulator_low_power,
    .call_isr, .isr_vector, .wdt_reset, .irq);
  swwd_core u_swwd_core (.sys_clk, .sleep_instr, .watchdog_clear_instruction);
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    {rd_en, addr} <= {1'b1, a};
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e, n);
  endtask
  // bounded wait for the core clock to reach level v
  task automatic wclk(input logic v, input int n);
    repeat (n) if (cpu_clk_en !== v) begin
      @(posedge sys_clk);
      #1;
    end
    chk({7'h0, cpu_clk_en}, {7'h0, v}, "cpu_clk_en");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000 bad_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(ADDR_REGULATOR_CONTROL, 8'h01, "regctl");
    rd(ADDR_WATCHDOG_CONTROL, 8'h16, "watchdog_control");
    wr(ADDR_REGULATOR_CONTROL, 8'hff);
    rd(ADDR_REGULATOR_CONTROL, 8'h03, "regctl");
    rd(4'hf, 8'h00, "unmapped");
    wr(ADDR_IRQ_MASK, 8'h07);
    irq_pending <= 1'b1;
    u_swwd_core.pulse(1'b1);
    repeat (3) @(posedge sys_clk);
    #1 wclk(1'b1, 1);
    rd(ADDR_CORE_STATUS, 8'h18, "status");
    chk({7'h0, irq}, 8'h01, "irq");
    rd(ADDR_IRQ_STATUS, 8'h04, "irqstat");
    chk({7'h0, irq}, 8'h00, "irq");
    $display("test nop sleep done");
    // low-power sleep holds the core until the regulator reports ready
    {irq_pending, global_interrupt_enable} <= 2'b00;
    u_swwd_core.pulse(1'b1);
    wclk(1'b0, 5);
    chk({7'h0, regulator_low_power}, 8'h01, "lowpower");
    rd(ADDR_CORE_STATUS, 8'h10, "status");
    irq_pending <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wclk(1'b0, 1);
    regulator_ready <= 1'b1;
    wclk(1'b1, 8);
    chk(n_isr, 8'h00, "isr count");
    {irq_pending, regulator_ready, lp_incompatible_active} <= 3'b001;
    u_swwd_core.pulse(1'b1);
    wclk(1'b0, 5);
    chk({7'h0, regulator_low_power}, 8'h00, "lowpower");
    {irq_pending, lp_incompatible_active} <= 2'b10;
    wclk(1'b1, 8);
    $display("test low power done");
    wr(ADDR_REGULATOR_CONTROL, 8'h01);
    {irq_pending, global_interrupt_enable} <= 2'b01;
    u_swwd_core.pulse(1'b1);
    wclk(1'b0, 5);
    irq_pending <= 1'b1;
    @(posedge sys_clk);
    #1 wclk(1'b1, 1);
    @(posedge sys_clk);
    #1 chk(n_isr, 8'h01, "isr count");
    rd(ADDR_IRQ_STATUS, 8'h01, "irqstat");
    irq_pending <= 1'b0;
    $display("test wake done");
    wr(ADDR_WATCHDOG_CONTROL, 8'h01);
    repeat (100) @(posedge sys_clk);
    chk(n_rst, 8'h00, "early reset");
    repeat (50) @(posedge sys_clk);
    chk(n_rst, 8'h01, "timeout");
    repeat (10) begin
      repeat (80) @(posedge sys_clk);
      u_swwd_core.pulse(1'b0);
    end
    chk(n_rst, 8'h01, "cleared");
    repeat (3) begin
      repeat (80) @(posedge sys_clk);
      osc_fail <= 1'b1;
      @(posedge sys_clk);
      osc_fail <= 1'b0;
    end
    chk(n_rst, 8'h01, "osc fail clear");
    oscillator_startup_timer <= 1'b1;
    repeat (200) @(posedge sys_clk);
    oscillator_startup_timer <= 1'b0;
    chk(n_rst, 8'h01, "startup hold");
    $display("test timeout done");
    watchdog_mode_config <= MODE_AWAKE;
    u_swwd_core.pulse(1'b1);
    repeat (200) @(posedge sys_clk);
    wclk(1'b0, 1);
    watchdog_mode_config <= MODE_ON;
    wclk(1'b1, 200);
    rd(ADDR_CORE_STATUS, 8'h00, "status");
    rd(ADDR_IRQ_STATUS, 8'h02, "irqstat");
    watchdog_mode_config <= MODE_OFF;
    repeat (300) @(posedge sys_clk);
    chk(n_rst, 8'h01, "mode off");
    $display("test modes done");
    finish_test();
  end
endmodule

// >>> verilog/swwd_ctrl.sv
// swwd_ctrl: sleep entry, wake-up, regulator mode and watchdog for a small core
// assumes: core pulses sleep_instr and watchdog_clear_instruction for one cycle;
// osc_tick is one sys_clk pulse per low-frequency oscillator period.
//
// Functional notes
// - pending enabled interrupt with global disable: sleep is a no-operation, only the no-op status bit sets
// - interrupt during or after sleep: wake at once, clear watchdog, set timeout, clear powerdown
// - wake with global enable calls vector 0004h, else continue in-line
// - regulator_power_mode bit selects low-power regulator state during sleep
// - waking from low-power sleep waits for regulator stabilisation before resuming
// - active low-power-incompatible peripheral forces normal regulator mode during sleep
// - reserved bit reads one after reset; upper six bits read zero
// - watchdog counts ticks of the independent 31 kHz oscillator, 1 ms base
// - mode 00 keeps watchdog always disabled
// - mode 11 keeps watchdog active always, including sleep
// - mode 10 active awake, disabled asleep
// - mode 01 follows watchdog_software_enable bit
// - awake time-out without clear resets the device
// - period select spans 1 ms to 256 s, resets to two seconds
// - counter clears on reset, clear, sleep entry, wake, osc fail, disable, startup timer
// - time-out asleep wakes device and updates flags instead of reset
// - code 0 is divide-by-32, doubling to 10010; higher codes give minimum
`timescale 1ns/1ns
module swwd_ctrl
  import swwd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [1:0] watchdog_mode_config,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instruction,
  input wire logic global_interrupt_enable,
  input wire logic irq_pending,
  input wire logic osc_tick,
  input wire logic osc_fail,
  input wire logic oscillator_startup_timer,
  input wire logic lp_incompatible_active,
  input wire logic regulator_ready,
  output logic cpu_clk_en,
  output logic regulator_low_power,
  output logic call_isr,
  output logic [15:0] isr_vector,
  output logic wdt_reset,
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    swwd_state_t st;
    logic pm;
    logic rsvd;
    logic to_flag;
    logic pd_flag;
    logic [4:0] ps;
    logic swen;
    logic [CNT_W-1:0] cnt;
    logic lp_slept;
    logic call;
    logic wrst;
    logic [2:0] ists;
    logic [2:0] imask;
    logic [7:0] rd;
  } swwd_regs_t;

  swwd_regs_t r_ff;
  swwd_regs_t nxt_r;

  logic asleep;
  logic wdt_active;
  logic [CNT_W-1:0] limit;
  logic timeout;
  logic wake;
  logic clr_cnt;
  logic [2:0] ev;

  // ****************************************
  // watchdog decode
  // ****************************************
  always_comb begin
    asleep = (r_ff.st != ST_RUN);
    unique case (watchdog_mode_config)
      MODE_OFF: wdt_active = 1'b0;
      MODE_SW: wdt_active = r_ff.swen;
      MODE_AWAKE: wdt_active = !asleep;
      MODE_ON: wdt_active = 1'b1;
    endcase
    // codes above the table fall back to 1:32
    if (r_ff.ps > PS_MAX) begin
      limit = CNT_W'(1) << PS_BASE_SHIFT;
    end else begin
      limit = CNT_W'(1) << (PS_BASE_SHIFT + int'(r_ff.ps));
    end
    timeout = wdt_active && osc_tick && (r_ff.cnt == limit - CNT_W'(1));
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.call = 1'b0;
    nxt_r.wrst = 1'b0;
    nxt_r.rd = 8'h00;
    wake = 1'b0;
    clr_cnt = 1'b0;
    ev = 3'h0;
    unique case (r_ff.st)
      ST_RUN: begin
        if (sleep_instr && !irq_pending) begin
          nxt_r.st = ST_SLEEP;
          nxt_r.to_flag = 1'b1;
          nxt_r.pd_flag = 1'b0;
          nxt_r.lp_slept = r_ff.pm && !lp_incompatible_active;
          clr_cnt = 1'b1;
        end
        // sleep with a pending source is dropped, only the no-op status bit is set
        if (timeout) begin
          nxt_r.wrst = 1'b1;
        end
      end
      ST_SLEEP: begin
        nxt_r.lp_slept = r_ff.lp_slept && r_ff.pm && !lp_incompatible_active;
        if (irq_pending) begin
          wake = 1'b1;
          nxt_r.to_flag = 1'b1;
          ev[IRQ_WAKE_BIT] = 1'b1;
        end else if (timeout) begin
          wake = 1'b1;
          nxt_r.to_flag = 1'b0;
          ev[IRQ_WDT_WAKE_BIT] = 1'b1;
        end
        if (wake) begin
          nxt_r.pd_flag = 1'b0;
          clr_cnt = 1'b1;
          nxt_r.st = r_ff.lp_slept ? ST_STAB : ST_RUN;
          nxt_r.call = !r_ff.lp_slept && global_interrupt_enable && irq_pending;
        end
      end
      ST_STAB: begin
        clr_cnt = 1'b1;
        if (regulator_ready) begin
          nxt_r.st = ST_RUN;
          nxt_r.lp_slept = 1'b0;
          nxt_r.call = global_interrupt_enable && irq_pending;
        end
      end
      default: nxt_r.st = ST_RUN;
    endcase
    if (sleep_instr && irq_pending && r_ff.st == ST_RUN) begin
      ev[IRQ_NOP_BIT] = 1'b1;
    end
    nxt_r.ists = r_ff.ists | ev;

    // counter
    if (clr_cnt || !wdt_active || watchdog_clear_instruction || osc_fail || oscillator_startup_timer
        || timeout) begin
      nxt_r.cnt = '0;
    end else if (osc_tick) begin
      nxt_r.cnt = r_ff.cnt + CNT_W'(1);
    end
    if (watchdog_clear_instruction) begin
      nxt_r.to_flag = 1'b1;
      nxt_r.pd_flag = 1'b1;
    end

    // register writes
    if (wr_en) begin
      unique case (addr)
        ADDR_REGULATOR_CONTROL: begin
          nxt_r.pm = wdata[REG_PM_BIT];
          nxt_r.rsvd = wdata[REG_RSVD_BIT];
        end
        ADDR_WATCHDOG_CONTROL: begin
          nxt_r.ps = wdata[WDC_PS_LSB +: 5];
          nxt_r.swen = wdata[WDC_SWEN_BIT];
        end
        ADDR_IRQ_MASK: nxt_r.imask = wdata[2:0];
        default: ;
      endcase
    end

    // register reads, data in the following cycle
    if (rd_en) begin
      unique case (addr)
        ADDR_REGULATOR_CONTROL: begin
          nxt_r.rd[REG_PM_BIT] = r_ff.pm;
          nxt_r.rd[REG_RSVD_BIT] = r_ff.rsvd;
        end
        ADDR_CORE_STATUS: begin
          nxt_r.rd[STAT_TO_BIT] = r_ff.to_flag;
          nxt_r.rd[STAT_PD_BIT] = r_ff.pd_flag;
        end
        ADDR_WATCHDOG_CONTROL: begin
          nxt_r.rd[WDC_PS_LSB +: 5] = r_ff.ps;
          nxt_r.rd[WDC_SWEN_BIT] = r_ff.swen;
        end
        ADDR_IRQ_STATUS: begin
          nxt_r.rd[2:0] = r_ff.ists;
          // clear on read, but events landing now survive
          nxt_r.ists = ev;
        end
        ADDR_IRQ_MASK: nxt_r.rd[2:0] = r_ff.imask;
        default: ;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_ff.st <= ST_RUN;
      r_ff.pm <= 1'b0;
      r_ff.rsvd <= 1'b1;
      r_ff.to_flag <= 1'b1;
      r_ff.pd_flag <= 1'b1;
      r_ff.ps <= PS_RESET;
      r_ff.swen <= 1'b0;
      r_ff.cnt <= '0;
      r_ff.lp_slept <= 1'b0;
      r_ff.call <= 1'b0;
      r_ff.wrst <= 1'b0;
      r_ff.ists <= 3'h0;
      r_ff.imask <= 3'h0;
      r_ff.rd <= 8'h00;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rdata = r_ff.rd;
  assign cpu_clk_en = (r_ff.st == ST_RUN);
  assign regulator_low_power = (r_ff.st == ST_SLEEP) && r_ff.lp_slept;
  assign call_isr = r_ff.call;
  assign isr_vector = ISR_VECTOR;
  assign wdt_reset = r_ff.wrst;
  assign irq = |(r_ff.ists & r_ff.imask);
endmodule

// >>> verilog/swwd_pkg.sv
// swwd_pkg: constants and types for the sleep, wake and watchdog controller
// assumes: sys_clk at 125 MHz, low_freq_internal_osc tick arrives as a one-cycle pulse
package swwd_pkg;
  // ****************************************
  // register map (indices chosen locally)
  // ****************************************
  localparam logic [3:0] ADDR_REGULATOR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CORE_STATUS = 4'h1;
  localparam logic [3:0] ADDR_WATCHDOG_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int REG_PM_BIT = 1;
  localparam int REG_RSVD_BIT = 0;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int WDC_PS_LSB = 1;
  localparam int WDC_SWEN_BIT = 0;
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic [4:0] PS_MAX = 5'h12;
  localparam int PS_BASE_SHIFT = 5;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;
  localparam logic [15:0] ISR_VECTOR = 16'h0004;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_WDT_WAKE_BIT = 1;
  localparam int IRQ_NOP_BIT = 2;
  localparam int CNT_W = 23;

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_STAB = 3'b100
  } swwd_state_t;
endpackage
